// ===== src/dds_core_pkg.sv
// Function
// - Phase accumulator is a modulo 2^48 counter stepped by the step word.
// - Every sample clock the 48-bit step word adds to the running total.
// - Overflow wraps and keeps the remainder; fout equals step/2^48 times fs.
// - A 14-bit phase offset shifts phase by 2*pi*offset/2^14.
// - Bit 0 of the loop control register selects open or closed loop.
// - Single-tone mode uses the stored single-tone step word, ignores references.
// - Single-tone mode ignores the step word's least significant bit.
// - Holdover reuses step words recorded while the loop was closed and valid.
// - Holdover is entered and left automatically or manually per configuration.
// - Closed loop feeds the accumulator with the loop filter step word.
// - The phase offset is not applied while the loop is closed.
// - A 10-bit DAC current scale spans two registers.
// - Coarse detector counts sample periods between reference and feedback edges.
// - Coarse gain uses a 3-bit shift and a 6-bit multiplier field.
// - Fine detector samples at fs over four times a 4-bit divider, reset 5.
// - Fine gain is an 8-bit field defaulting to 200.
// - Fine result is the phase error unless it over- or underflows.
package dds_core_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ACC_W = 48;
  localparam int PHS_W = 14;
  localparam int AMP_W = 14;
  localparam int FSC_W = 10;
  localparam int CPD_W = 18;
  localparam int FPD_W = 12;
  localparam int ERR_W = 32;

  // ****************************************************************
  // Register word indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [11:0] IDX_FINE_DIV = 12'h023;
  localparam logic [11:0] IDX_LOOP_CTRL = 12'h100;
  localparam logic [11:0] IDX_FINE_GAIN = 12'h404;
  localparam logic [11:0] IDX_FSC_LOW = 12'h40b;
  localparam logic [11:0] IDX_FSC_HIGH = 12'h40c;
  localparam logic [11:0] IDX_COARSE_GAIN = 12'h405;
  localparam logic [11:0] IDX_PHASE_OFS = 12'h406;
  localparam logic [11:0] IDX_TONE_LO = 12'h407;
  localparam logic [11:0] IDX_TONE_HI = 12'h408;
  localparam logic [11:0] IDX_STATUS = 12'h409;

  // ****************************************************************
  // Control bit positions
  // ****************************************************************
  localparam int CTL_CLOSE = 0;
  localparam int CTL_TONE = 1;
  localparam int CTL_HOLD_MAN = 2;
  localparam int CTL_HOLD_AUTO = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [3:0] FINE_DIV_RST = 4'h5;
  localparam logic [7:0] FINE_GAIN_RST = 8'hc8;
  localparam logic [FSC_W-1:0] FSC_RST = 10'h200;
  localparam logic [7:0] CTRL_RST = 8'h00;

  typedef enum logic [1:0] {
    MODE_TONE,
    MODE_HOLD,
    MODE_CLOSED
  } mode_t;

endpackage

// ===== src/phase_to_sine.sv
`timescale 1ns/1ps
`default_nettype none
module phase_to_sine
  import dds_core_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Phase in, amplitude out
  input wire logic [PHS_W-1:0] phase,
  output logic [AMP_W-1:0] sample
);

  // ****************************************************************
  // Triangle approximation of a sine; a ROM would cost area here
  // ****************************************************************
  logic [PHS_W-2:0] ramp;

  always_comb begin
    ramp = {1'b0, phase[PHS_W-2] ? ~phase[PHS_W-3:0] : phase[PHS_W-3:0]};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sample <= '0;
    end else begin
      sample <= phase[PHS_W-1] ? {1'b0, ramp} : {1'b1, ~ramp};
    end
  end

endmodule
`default_nettype wire

// ===== src/phase_error_select.sv
`timescale 1ns/1ps
`default_nettype none
module phase_error_select
  import dds_core_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Detector results
  input wire logic [CPD_W-1:0] coarse_count,
  input wire logic [2:0] coarse_gain_shift,
  input wire logic [5:0] coarse_gain_multiplier,
  input wire logic [FPD_W-1:0] fine_result,
  input wire logic [7:0] fine_gain_scale,
  input wire logic fine_over,
  input wire logic fine_under,
  input wire logic strobe,
  // Selected error
  output logic [ERR_W-1:0] phase_error,
  output logic used_coarse
);

  logic [ERR_W-1:0] coarse_scaled;
  logic [ERR_W-1:0] fine_scaled;

  always_comb begin
    coarse_scaled = ERR_W'(({14'h0000, coarse_count} * coarse_gain_multiplier) << coarse_gain_shift);
    fine_scaled = ERR_W'({20'h00000, fine_result} * fine_gain_scale);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_error <= '0;
      used_coarse <= 1'b0;
    end else if (strobe) begin
      if (fine_over || fine_under) begin
        phase_error <= coarse_scaled;
        used_coarse <= 1'b1;
      end else begin
        phase_error <= fine_scaled;
        used_coarse <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== src/dds_core.sv
`timescale 1ns/1ps
`default_nettype none
module dds_core
  import dds_core_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Loop filter step word and lock
  input wire logic [ACC_W-1:0] filter_step_word,
  input wire logic loop_valid,
  input wire logic ref_lost,
  // Detector edges (asynchronous pins)
  input wire logic ref_edge,
  input wire logic fbk_edge,
  // Fine detector result, valid on its sample tick
  input wire logic [FPD_W-1:0] fine_result,
  input wire logic fine_over,
  input wire logic fine_under,
  // Outputs
  output logic [AMP_W-1:0] dac_sample,
  output logic [FSC_W-1:0] dac_current_scale,
  output logic fine_sample_tick,
  output logic [ERR_W-1:0] phase_error,
  output logic error_from_coarse
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [3:0] fine_sample_divider_r;
  logic [7:0] pll_loop_control_r;
  logic [7:0] fine_gain_scale_r;
  logic [FSC_W-1:0] fsc_r;
  logic [2:0] coarse_gain_shift_r;
  logic [5:0] coarse_gain_multiplier_r;
  logic [PHS_W-1:0] phase_offset_r;
  logic [ACC_W-1:0] single_tone_step_word_r;
  logic [ACC_W-1:0] hold_word_r;
  logic hold_ok_r;
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] frequency_step_word;
  logic [PHS_W-1:0] phase_word;
  logic [5:0] fine_cnt_r;
  logic [CPD_W-1:0] coarse_cnt_r;
  logic [CPD_W-1:0] coarse_hold_r;
  logic [2:0] ref_sync_r;
  logic [2:0] fbk_sync_r;
  logic ref_lvl_r;
  logic fbk_lvl_r;
  logic coarse_run_r;
  logic coarse_done_r;
  mode_t mode;

  function automatic logic hit(input logic [15:0] a, input logic [11:0] idx);
    hit = (a[15:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
  endfunction

  logic wr;
  logic rd_any;
  logic mapped;
  assign wr = psel && penable && pwrite;
  assign rd_any = psel && !penable;
  assign mapped = hit(paddr, IDX_FINE_DIV) || hit(paddr, IDX_LOOP_CTRL) ||
    hit(paddr, IDX_FINE_GAIN) || hit(paddr, IDX_FSC_LOW) || hit(paddr, IDX_FSC_HIGH) ||
    hit(paddr, IDX_COARSE_GAIN) || hit(paddr, IDX_PHASE_OFS) ||
    hit(paddr, IDX_TONE_LO) || hit(paddr, IDX_TONE_HI) || hit(paddr, IDX_STATUS);

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fine_sample_divider_r <= FINE_DIV_RST;
      pll_loop_control_r <= CTRL_RST;
      fine_gain_scale_r <= FINE_GAIN_RST;
      fsc_r <= FSC_RST;
      coarse_gain_shift_r <= '0;
      coarse_gain_multiplier_r <= '0;
      phase_offset_r <= '0;
      single_tone_step_word_r <= '0;
    end else if (wr) begin
      if (hit(paddr, IDX_FINE_DIV)) fine_sample_divider_r <= pwdata[3:0];
      if (hit(paddr, IDX_LOOP_CTRL)) pll_loop_control_r <= pwdata[7:0];
      if (hit(paddr, IDX_FINE_GAIN)) fine_gain_scale_r <= pwdata[7:0];
      if (hit(paddr, IDX_FSC_LOW)) fsc_r[7:0] <= pwdata[7:0];
      if (hit(paddr, IDX_FSC_HIGH)) fsc_r[9:8] <= pwdata[1:0];
      if (hit(paddr, IDX_COARSE_GAIN)) begin
        coarse_gain_shift_r <= pwdata[2:0];
        coarse_gain_multiplier_r <= pwdata[13:8];
      end
      if (hit(paddr, IDX_PHASE_OFS)) phase_offset_r <= pwdata[PHS_W-1:0];
      if (hit(paddr, IDX_TONE_LO)) single_tone_step_word_r[31:0] <= pwdata;
      if (hit(paddr, IDX_TONE_HI)) single_tone_step_word_r[47:32] <= pwdata[15:0];
    end
  end

  // ****************************************************************
  // APB answer: zero wait states, unmapped reads zero with error
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_any;
      pslverr <= rd_any && !mapped;
      prdata <= '0;
      if (rd_any && !pwrite) begin
        if (hit(paddr, IDX_FINE_DIV)) prdata <= {28'h0000000, fine_sample_divider_r};
        if (hit(paddr, IDX_LOOP_CTRL)) prdata <= {24'h000000, pll_loop_control_r};
        if (hit(paddr, IDX_FINE_GAIN)) prdata <= {24'h000000, fine_gain_scale_r};
        if (hit(paddr, IDX_FSC_LOW)) prdata <= {24'h000000, fsc_r[7:0]};
        if (hit(paddr, IDX_FSC_HIGH)) prdata <= {30'h00000000, fsc_r[9:8]};
        if (hit(paddr, IDX_COARSE_GAIN)) begin
          prdata <= {18'h00000, coarse_gain_multiplier_r, 5'h00, coarse_gain_shift_r};
        end
        if (hit(paddr, IDX_PHASE_OFS)) prdata <= {18'h00000, phase_offset_r};
        if (hit(paddr, IDX_TONE_LO)) prdata <= single_tone_step_word_r[31:0];
        if (hit(paddr, IDX_TONE_HI)) prdata <= {16'h0000, single_tone_step_word_r[47:32]};
        if (hit(paddr, IDX_STATUS)) begin
          prdata <= {28'h0000000, hold_ok_r, 1'b0, 2'(mode)};
        end
      end
    end
  end

  // ****************************************************************
  // Mode selection
  // ****************************************************************
  // Automatic holdover drops out of the loop when the reference is lost
  always_comb begin
    if (pll_loop_control_r[CTL_TONE]) begin
      mode = MODE_TONE;
    end else if (!pll_loop_control_r[CTL_CLOSE]) begin
      mode = hold_ok_r ? MODE_HOLD : MODE_TONE;
    end else if (hold_ok_r && (pll_loop_control_r[CTL_HOLD_MAN] ||
        (pll_loop_control_r[CTL_HOLD_AUTO] && ref_lost))) begin
      mode = MODE_HOLD;
    end else begin
      mode = MODE_CLOSED;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_word_r <= '0;
      hold_ok_r <= 1'b0;
    end else if (mode == MODE_CLOSED && loop_valid) begin
      hold_word_r <= filter_step_word;
      hold_ok_r <= 1'b1;
    end
  end

  always_comb begin
    case (mode)
      MODE_TONE: frequency_step_word = {single_tone_step_word_r[ACC_W-1:1], 1'b0};
      MODE_HOLD: frequency_step_word = hold_word_r;
      MODE_CLOSED: frequency_step_word = filter_step_word;
      default: frequency_step_word = '0;
    endcase
  end

  // ****************************************************************
  // Accumulator; the carry out is dropped so the excess is kept
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_r <= '0;
    end else begin
      acc_r <= ACC_W'(acc_r + frequency_step_word);
    end
  end

  always_comb begin
    if (mode == MODE_CLOSED) begin
      phase_word = acc_r[ACC_W-1 -: PHS_W];
    end else begin
      phase_word = PHS_W'(acc_r[ACC_W-1 -: PHS_W] + phase_offset_r);
    end
  end

  phase_to_sine u_sine (
    .mclk(mclk),
    .rst(rst),
    .phase(phase_word),
    .sample(dac_sample)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dac_current_scale <= FSC_RST;
    end else begin
      dac_current_scale <= fsc_r;
    end
  end

  // ****************************************************************
  // Fine detector sample tick: one pulse every 4 x divider cycles
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fine_cnt_r <= '0;
      fine_sample_tick <= 1'b0;
    end else if (fine_cnt_r >= 6'({fine_sample_divider_r, 2'b00}) - 6'h01) begin
      fine_cnt_r <= '0;
      fine_sample_tick <= 1'b1;
    end else begin
      fine_cnt_r <= 6'(fine_cnt_r + 6'h01);
      fine_sample_tick <= 1'b0;
    end
  end

  // ****************************************************************
  // Coarse detector: counts fs periods from a reference edge to a
  // feedback edge; the count saturates rather than wrapping
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ref_sync_r <= '0;
      fbk_sync_r <= '0;
      ref_lvl_r <= 1'b0;
      fbk_lvl_r <= 1'b0;
    end else begin
      ref_sync_r <= {ref_sync_r[1:0], ref_edge};
      fbk_sync_r <= {fbk_sync_r[1:0], fbk_edge};
      if (ref_sync_r[1] == ref_sync_r[2]) ref_lvl_r <= ref_sync_r[2];
      if (fbk_sync_r[1] == fbk_sync_r[2]) fbk_lvl_r <= fbk_sync_r[2];
    end
  end

  logic ref_rise;
  logic fbk_rise;
  assign ref_rise = (ref_sync_r[1] == ref_sync_r[2]) && ref_sync_r[2] && !ref_lvl_r;
  assign fbk_rise = (fbk_sync_r[1] == fbk_sync_r[2]) && fbk_sync_r[2] && !fbk_lvl_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      coarse_run_r <= 1'b0;
      coarse_cnt_r <= '0;
      coarse_hold_r <= '0;
      coarse_done_r <= 1'b0;
    end else begin
      coarse_done_r <= 1'b0;
      if (ref_rise && !coarse_run_r) begin
        coarse_run_r <= 1'b1;
        // The period that ends at the feedback edge is counted as well
        coarse_cnt_r <= CPD_W'(1);
      end else if (coarse_run_r && fbk_rise) begin
        coarse_run_r <= 1'b0;
        coarse_hold_r <= coarse_cnt_r;
        coarse_done_r <= 1'b1;
      end else if (coarse_run_r && coarse_cnt_r != '1) begin
        coarse_cnt_r <= CPD_W'(coarse_cnt_r + 1'b1);
      end
    end
  end

  // Fine result is taken on its tick; the coarse count stays valid meanwhile
  phase_error_select u_sel (
    .mclk(mclk),
    .rst(rst),
    .coarse_count(coarse_hold_r),
    .coarse_gain_shift(coarse_gain_shift_r),
    .coarse_gain_multiplier(coarse_gain_multiplier_r),
    .fine_result(fine_result),
    .fine_gain_scale(fine_gain_scale_r),
    .fine_over(fine_over),
    .fine_under(fine_under),
    .strobe(fine_sample_tick),
    .phase_error(phase_error),
    .used_coarse(error_from_coarse)
  );

endmodule
`default_nettype wire

// ===== verification/dds_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dds_core_chk
  import dds_core_pkg::*;
(
  // Bus side
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core side
  input wire logic fine_over,
  input wire logic fine_under,
  input wire logic [FSC_W-1:0] dac_current_scale,
  input wire logic fine_sample_tick,
  input wire logic error_from_coarse
);
  // ****
  // Tick spacing
  // ****
  logic [3:0] div_r;
  logic [7:0] gap_r;
  logic armed_r;
  logic div_wr;
  assign div_wr = psel && penable && pwrite && paddr == 16'h008c;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_r <= FINE_DIV_RST;
    end else if (div_wr) begin
      div_r <= pwdata[3:0];
    end
  end
  // A period that straddles a divider write is not judged
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gap_r <= 8'h00;
      armed_r <= 1'b0;
    end else begin
      gap_r <= fine_sample_tick ? 8'h00 : gap_r + 8'h01;
      armed_r <= !div_wr && (armed_r || fine_sample_tick);
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  tick_gap_a:
    assert property (fine_sample_tick && armed_r |-> gap_r == {2'b00, div_r, 2'b00} - 8'h01)
      else $error("fine tick spacing wrong");
  scale_load_a:
    assert property (psel && penable && pwrite && paddr == 16'h102c |->
      ##2 dac_current_scale[7:0] == $past(pwdata[7:0], 2)) else $error("scale not loaded");
  scale_reset_a:
    assert property ($fell(rst) |-> dac_current_scale == FSC_RST && !pready)
      else $error("reset scale wrong");
  err_source_a:
    assert property (fine_sample_tick ##1 ($stable(fine_over) && $stable(fine_under)) |->
      ##2 error_from_coarse == $past(fine_over || fine_under, 3)) else $error("bad source");
  ready_after_a:
    assert property (psel && !penable |=> pready) else $error("no ready in access");
  ready_once_a:
    assert property (pready |=> !pready) else $error("ready held too long");
  misalign_a:
    assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
      else $error("misaligned not refused");
  refused_zero_a:
    assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
  cover property (fine_sample_tick && armed_r);
  cover property (pready && pslverr);
  cover property (error_from_coarse);
endmodule
bind dds_core dds_core_chk dds_core_chk_i (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fine_over(fine_over), .fine_under(fine_under),
  .dac_current_scale(dac_current_scale), .fine_sample_tick(fine_sample_tick),
  .error_from_coarse(error_from_coarse));
`default_nettype wire

// ===== verification/dac_model.sv
`timescale 1ns/1ps
`default_nettype none
module dac_model
  import dds_core_pkg::*;
#(
  parameter longint IREF_NA = 120000
)
(
  // Digital side
  input wire logic mclk,
  input wire logic [AMP_W-1:0] dac_sample,
  input wire logic [FSC_W-1:0] dac_current_scale,
  // Analog view in nA
  output var longint fs_na,
  output var longint out_na
);
  // ****
  // Converter
  // ****
  always_comb begin
    fs_na = IREF_NA * (72 * 1024 + 192 * longint'(dac_current_scale)) / 1024;
  end
  // Latched one sample late, as the output stage holds each code a full period
  always_ff @(posedge mclk) begin
    out_na <= fs_na * longint'(dac_sample) / (longint'(1) << AMP_W);
  end
endmodule
`default_nettype wire

// ===== verification/tb_dds_core.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %0h want %0h", $time, g, e); end end
module tb_dds_core
  import dds_core_pkg::*;
;
  // ****
  // Design and converter
  // ****
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, loop_valid, ref_lost;
  logic ref_edge, fbk_edge, fine_over, fine_under, fine_sample_tick, error_from_coarse;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [ACC_W-1:0] filter_step_word;
  logic [FPD_W-1:0] fine_result;
  logic [AMP_W-1:0] dac_sample;
  logic [FSC_W-1:0] dac_current_scale;
  logic [ERR_W-1:0] phase_error;
  longint fs_na;
  int checked, bad_count, cyc;
  dds_core dds_core_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .filter_step_word(filter_step_word), .loop_valid(loop_valid),
    .ref_lost(ref_lost), .ref_edge(ref_edge), .fbk_edge(fbk_edge),
    .fine_result(fine_result), .fine_over(fine_over), .fine_under(fine_under),
    .dac_sample(dac_sample), .dac_current_scale(dac_current_scale),
    .phase_error(phase_error),
    .fine_sample_tick(fine_sample_tick), .error_from_coarse(error_from_coarse));
  dac_model dac_model_i (.mclk(mclk), .dac_sample(dac_sample),
    .dac_current_scale(dac_current_scale), .fs_na(fs_na), .out_na());
  always #12.5 mclk = ~mclk;
  // A hang anywhere ends in the same report
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      summarize();
    end
  end
  // ****
  // Bus tasks
  // ****
  function automatic logic [15:0] ba(input logic [11:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  // Leading edge keeps two transfers from touching psel in one time step
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge mclk);
    end
    if (n == 100) bad_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, ba(i), d, r, e);
  endtask
  task automatic rd(input logic [11:0] i, output logic [31:0] r);
    logic e;
    apb(1'b0, ba(i), 32'h0, r, e);
  endtask
  task automatic per4();
    logic [AMP_W-1:0] s [5];
    repeat (6) @(posedge mclk);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      s[i] = dac_sample;
    end
    `CHK(s[4], s[0])
    `CHK(s[1] !== s[3], 1'b1)
  endtask
  task automatic ofs(input logic [13:0] v, output logic [AMP_W-1:0] s);
    wr(IDX_PHASE_OFS, {18'h0, v});
    repeat (6) @(posedge mclk);
    s = dac_sample;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd(IDX_FINE_DIV, r);
    `CHK(r, 32'h5)
    rd(IDX_FINE_GAIN, r);
    `CHK(r, 32'hc8)
    rd(IDX_FSC_HIGH, r);
    `CHK(r, 32'h2)
    rd(IDX_STATUS, r);
    `CHK(r, 32'h0)
    apb(1'b0, 16'h0ffc, 32'h0, r, e);
    `CHK({e, r}, 33'h1_0000_0000)
    apb(1'b1, 16'h008d, 32'h3, r, e);
    `CHK(e, 1'b1)
    wr(IDX_COARSE_GAIN, 32'h3f07);
    rd(IDX_COARSE_GAIN, r);
    `CHK(r, 32'h3f07)
    wr(IDX_FSC_LOW, 32'hff);
    wr(IDX_FSC_HIGH, 32'h3);
    repeat (3) @(posedge mclk);
    `CHK(fs_na, longint'(120000) * (72 * 1024 + 192 * 1023) / 1024)
    $display("register test done");
  endtask
  task automatic t_tick();
    int n;
    wr(IDX_FINE_DIV, 32'h2);
    repeat (2) begin
      @(posedge mclk);
      while (fine_sample_tick !== 1'b1) @(posedge mclk);
    end
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (fine_sample_tick !== 1'b1);
    `CHK(n, 4 * 2)
    $display("tick test done");
  endtask
  task automatic t_modes();
    logic [31:0] r;
    logic [AMP_W-1:0] a, b;
    wr(IDX_TONE_HI, 32'h4000);
    wr(IDX_LOOP_CTRL, 32'h2);
    rd(IDX_STATUS, r);
    `CHK(r[1:0], MODE_TONE)
    per4();
    wr(IDX_TONE_HI, 32'h0);
    ofs(14'h0800, a);
    ofs(14'h2800, b);
    `CHK(a !== b, 1'b1)
    filter_step_word <= 48'h4000_0000_0000;
    loop_valid <= 1'b1;
    wr(IDX_LOOP_CTRL, 32'h1);
    rd(IDX_STATUS, r);
    `CHK(r[1:0], MODE_CLOSED)
    per4();
    wr(IDX_LOOP_CTRL, 32'h5);
    rd(IDX_STATUS, r);
    `CHK({r[3], r[1:0]}, {1'b1, MODE_HOLD})
    loop_valid <= 1'b0;
    filter_step_word <= '0;
    per4();
    ofs(14'h0800, a);
    wr(IDX_LOOP_CTRL, 32'h9);
    ofs(14'h0800, a);
    ofs(14'h2800, b);
    `CHK(a, b)
    ref_lost <= 1'b1;
    rd(IDX_STATUS, r);
    `CHK(r[1:0], MODE_HOLD)
    ref_lost <= 1'b0;
    rd(IDX_STATUS, r);
    `CHK(r[1:0], MODE_CLOSED)
    $display("mode test done");
  endtask
  task automatic t_select();
    for (int i = 0; i < 3; i++) begin
      fine_over <= (i == 1);
      fine_under <= (i == 2);
      fine_result <= FPD_W'(i * 300 + 100);
      ref_edge <= 1'b1;
      repeat (3) @(posedge mclk);
      fbk_edge <= 1'b1;
      repeat (30) @(posedge mclk);
      ref_edge <= 1'b0;
      fbk_edge <= 1'b0;
      `CHK(error_from_coarse, i != 0)
      `CHK(phase_error, (i == 0) ? 32'h00004e20 : 32'h00005e80)
      // Let both lows pass the synchroniser so the next rise is seen
      repeat (6) @(posedge mclk);
    end
    $display("select test done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {mclk, rst, cyc, checked, bad_count} = {2'b01, 96'h0};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {filter_step_word, loop_valid, ref_lost, ref_edge, fbk_edge} = '0;
    {fine_result, fine_over, fine_under} = '0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_tick();
    t_modes();
    t_select();
    summarize();
  end
endmodule
`default_nettype wire
